// >>> pd_regs.svh
// Bit positions, reset values and timing counts for the power-down and reset control block.
`ifndef PD_REGS_SVH
`define PD_REGS_SVH

// Command register layout.
`define CMD_CODE_LSB      0
`define CMD_CODE_W        4
`define CMD_SLEEP_BIT     4
`define CMD_KICK_BIT      5
`define CMD_IDLE          4'h0

// Antenna control register layout.
`define ANT_EN1_BIT       0
`define ANT_EN2_BIT       1
`define ANT_RESET         8'h00

// Status readback layout.
`define STAT_READY_BIT    0
`define STAT_SOFT_BIT     1
`define STAT_WAKE_BIT     2

// Timing figures.
`define PD_CLK_PERIOD_NS  5
`define PD_SPIKE_NS       10
`define PD_STARTUP_CLOCKS 1024
`define PD_WAKE_CLOCKS    1024

`endif

// >>> pd_pkg.sv
// Types shared by the power-down and reset control block.
`default_nettype none

package pd_pkg;

  // Power state of the device.
  typedef enum logic [2:0] {
    ST_HARD_PD,
    ST_OSC_WAIT,
    ST_STARTUP,
    ST_ACTIVE,
    ST_SOFT_PD,
    ST_WAKE
  } pwr_state_t;

  typedef logic [7:0] reg_byte_t;

endpackage : pd_pkg

`default_nettype wire

// >>> reset_spike_filter.sv
// Spike filter that passes a level change only after it has persisted.
`default_nettype none

module reset_spike_filter #(
  parameter int MIN_CYCLES = 2
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      level
);

  localparam int CW = $clog2(MIN_CYCLES + 1);

  logic          level_q;
  logic          level_d;
  logic [CW-1:0] run_q;
  logic [CW-1:0] run_d;

  if (MIN_CYCLES < 1)
  begin : g_chk
    $error("reset_spike_filter needs MIN_CYCLES of at least one");
  end

  // A differing pin value must stand MIN_CYCLES cycles before the output follows.
  always_comb
  begin
    level_d = level_q;
    run_d   = '0;
    if (pin != level_q)
    begin
      if (run_q == CW'(MIN_CYCLES - 1))
      begin
        level_d = pin;
      end
      else
      begin
        run_d = run_q + 1'b1;
      end
    end
  end

  // Reset starts in the power-down level so the device comes up through start-up.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      level_q <= 1'b0;
      run_q   <= '0;
    end
    else
    begin
      level_q <= level_d;
      run_q   <= run_d;
    end
  end

  assign level = level_q;

endmodule : reset_spike_filter

`default_nettype wire

// >>> startup_delay_counter.sv
// Cycle counter that flags the last cycle of a fixed delay.
`default_nettype none

module startup_delay_counter #(
  parameter int COUNT = 1024
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic clear,
  input  wire logic run,
  output logic      done
);

  localparam int CW = $clog2(COUNT + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  if (COUNT < 1)
  begin : g_chk
    $error("startup_delay_counter needs COUNT of at least one");
  end

  // Done marks the COUNT-th running cycle; the count holds there until cleared.
  assign done = run && (cnt_q == CW'(COUNT - 1));

  always_comb
  begin
    cnt_d = cnt_q;
    if (clear)
    begin
      cnt_d = '0;
    end
    else if (run && !done)
    begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

endmodule : startup_delay_counter

`default_nettype wire

// >>> power_down_reset_control.sv
// Power-down, reset filtering and start-up control of the reader front end.
`include "pd_regs.svh"
`default_nettype none

module power_down_reset_control #(
  parameter int PAD_W          = 4,
  parameter int IN_W           = 4,
  parameter int STARTUP_CLOCKS = `PD_STARTUP_CLOCKS,
  parameter int WAKE_CLOCKS    = `PD_WAKE_CLOCKS
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             power_down_reset_n,
  input  wire logic             clock_stable,
  input  wire logic             host_wr_command,
  input  wire logic             host_wr_antenna,
  input  wire pd_pkg::reg_byte_t host_wdata,
  input  wire logic             command_done,
  input  wire logic [IN_W-1:0]  pad_in,
  input  wire logic [PAD_W-1:0] pad_out_core,
  output pd_pkg::reg_byte_t     command_readback,
  output pd_pkg::reg_byte_t     antenna_readback,
  output pd_pkg::reg_byte_t     status_readback,
  output logic                  host_ready,
  output logic                  osc_enable,
  output logic                  osc_buffer_enable,
  output logic                  current_sinks_on,
  output logic                  input_isolate,
  output logic [IN_W-1:0]       pad_in_core,
  output logic [PAD_W-1:0]      pad_out,
  output logic                  antenna_drivers_on,
  output logic                  core_kick
);

  import pd_pkg::*;

  // Least time rounds up to whole cycles of the 200 MHz clock.
  localparam int SPIKE_CYCLES =
    (`PD_SPIKE_NS + `PD_CLK_PERIOD_NS - 1) / `PD_CLK_PERIOD_NS;

  if (PAD_W < 1 || IN_W < 1)
  begin : g_chk
    $error("power_down_reset_control needs at least one pad of each kind");
  end

  pwr_state_t               state_q;
  pwr_state_t               state_d;
  logic                     sleep_q;
  logic                     sleep_d;
  logic [`CMD_CODE_W-1:0]   cmd_q;
  logic [`CMD_CODE_W-1:0]   cmd_d;
  reg_byte_t                ant_q;
  reg_byte_t                ant_d;
  logic                     kick_q;
  logic                     kick_d;
  logic [PAD_W-1:0]         pad_q;
  logic [PAD_W-1:0]         pad_d;
  logic                     pin_ok;
  logic                     hard_pd;
  logic                     host_ok;
  logic                     wr_cmd;
  logic                     wr_ant;
  logic                     st_clear;
  logic                     st_run;
  logic                     st_done;
  logic                     wk_clear;
  logic                     wk_run;
  logic                     wk_done;
  logic [15:0]              len_q; // Cycles spent in the current state, for the checks.
  logic [15:0]              len_d;

  // The pin passes the spike filter before it can start a hard power-down.
  reset_spike_filter #(
    .MIN_CYCLES (SPIKE_CYCLES)
  ) u_filter (
    .clk    (clk),
    .resetn (resetn),
    .pin    (power_down_reset_n),
    .level  (pin_ok)
  );

  startup_delay_counter #(
    .COUNT (STARTUP_CLOCKS)
  ) u_startup (
    .clk    (clk),
    .resetn (resetn),
    .clear  (st_clear),
    .run    (st_run),
    .done   (st_done)
  );

  startup_delay_counter #(
    .COUNT (WAKE_CLOCKS)
  ) u_wake (
    .clk    (clk),
    .resetn (resetn),
    .clear  (wk_clear),
    .run    (wk_run),
    .done   (wk_done)
  );

  // Host strobes count only once the device answers; inputs stay live in soft power-down.
  assign hard_pd = !pin_ok;
  assign host_ok = (state_q == ST_ACTIVE) || (state_q == ST_SOFT_PD) || (state_q == ST_WAKE);
  assign wr_cmd  = host_wr_command && host_ok && !hard_pd;
  assign wr_ant  = host_wr_antenna && (state_q == ST_ACTIVE) && !hard_pd;

  // Power sequencing; hard power-down overrides everything and returns the registers to reset.
  always_comb
  begin
    state_d  = state_q;
    sleep_d  = sleep_q;
    cmd_d    = cmd_q;
    ant_d    = ant_q;
    kick_d   = 1'b0;
    st_clear = 1'b0;
    st_run   = 1'b0;
    wk_clear = 1'b0;
    wk_run   = 1'b0;
    if (hard_pd)
    begin
      state_d  = ST_HARD_PD;
      sleep_d  = 1'b0;
      cmd_d    = `CMD_IDLE;
      ant_d    = `ANT_RESET;
      st_clear = 1'b1;
      wk_clear = 1'b1;
    end
    else
    begin
      unique case (state_q)
        ST_HARD_PD:
        begin
          state_d = ST_OSC_WAIT;
        end
        ST_OSC_WAIT:
        begin
          st_clear = 1'b1;
          if (clock_stable)
          begin
            state_d = ST_STARTUP;
          end
        end
        ST_STARTUP:
        begin
          // A clock that drops out restarts the whole delay.
          if (!clock_stable)
          begin
            state_d = ST_OSC_WAIT;
          end
          else
          begin
            st_run = 1'b1;
            if (st_done)
            begin
              state_d = ST_ACTIVE;
            end
          end
        end
        ST_ACTIVE:
        begin
          wk_clear = 1'b1;
          // Hardware returns the command to idle; a host write in the same cycle wins.
          if (command_done)
          begin
            cmd_d = `CMD_IDLE;
          end
          if (wr_cmd)
          begin
            cmd_d  = host_wdata[`CMD_CODE_LSB +: `CMD_CODE_W];
            kick_d = host_wdata[`CMD_KICK_BIT];
            if (host_wdata[`CMD_SLEEP_BIT])
            begin
              sleep_d = 1'b1;
              state_d = ST_SOFT_PD;
            end
          end
          if (wr_ant)
          begin
            ant_d = host_wdata;
          end
        end
        ST_SOFT_PD:
        begin
          wk_clear = 1'b1;
          if (wr_cmd && !host_wdata[`CMD_SLEEP_BIT])
          begin
            state_d = ST_WAKE;
          end
        end
        ST_WAKE:
        begin
          // The sleep bit keeps reading one until the count has run out.
          if (wr_cmd && host_wdata[`CMD_SLEEP_BIT])
          begin
            wk_clear = 1'b1;
            state_d  = ST_SOFT_PD;
          end
          else
          begin
            wk_run = 1'b1;
            if (wk_done)
            begin
              sleep_d = 1'b0;
              state_d = ST_ACTIVE;
            end
          end
        end
      endcase
    end
    len_d = (state_d == state_q) ? len_q + 16'h0001 : 16'h0000;
  end

  // Output pins follow the core only while active; otherwise they hold.
  always_comb
  begin
    pad_d = pad_q;
    if (state_q == ST_ACTIVE && !hard_pd)
    begin
      pad_d = pad_out_core;
    end
  end

  // Register contents are untouched by soft power-down; a hard power-down returns them all to reset.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_HARD_PD;
      sleep_q <= 1'b0;
      cmd_q   <= `CMD_IDLE;
      ant_q   <= `ANT_RESET;
      kick_q  <= 1'b0;
      pad_q   <= '0;
      len_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      sleep_q <= sleep_d;
      cmd_q   <= cmd_d;
      ant_q   <= ant_d;
      kick_q  <= kick_d;
      pad_q   <= pad_d;
      len_q   <= len_d;
    end
  end

  // Readback: the kick bit is write-only, status bits come from the state alone.
  always_comb
  begin
    command_readback                                   = '0;
    command_readback[`CMD_CODE_LSB +: `CMD_CODE_W]      = cmd_q;
    command_readback[`CMD_SLEEP_BIT]                    = sleep_q;
    command_readback[`CMD_KICK_BIT]                     = 1'b0;
    status_readback                                    = '0;
    status_readback[`STAT_READY_BIT] = (state_q == ST_ACTIVE);
    status_readback[`STAT_SOFT_BIT]  = (state_q == ST_SOFT_PD) || (state_q == ST_WAKE);
    status_readback[`STAT_WAKE_BIT]  = (state_q == ST_WAKE);
  end

  // Power controls. Inputs are clamped low in hard power-down so floating pads cannot toggle logic.
  assign antenna_readback   = ant_q;
  assign host_ready         = (state_q == ST_ACTIVE);
  assign osc_enable         = (state_q != ST_HARD_PD);
  assign osc_buffer_enable  = (state_q != ST_HARD_PD) && (state_q != ST_SOFT_PD);
  assign current_sinks_on   = osc_buffer_enable;
  assign input_isolate      = hard_pd || (state_q == ST_HARD_PD);
  assign pad_in_core        = input_isolate ? '0 : pad_in;
  assign pad_out            = pad_q;
  assign antenna_drivers_on = ant_q[`ANT_EN1_BIT] && ant_q[`ANT_EN2_BIT]
                              && (state_q == ST_ACTIVE);
  assign core_kick          = kick_q;

  hard_osc_a: assert property (@(posedge clk) disable iff (!resetn)
    hard_pd |=> !osc_enable && !current_sinks_on) else $error("osc on in hard pd");
  clamp_in_a: assert property (@(posedge clk) disable iff (!resetn)
    hard_pd |-> input_isolate && pad_in_core == '0) else $error("inputs not clamped");
  freeze_out_a: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ST_HARD_PD |=> $stable(pad_out)) else $error("pads moved in hard pd");
  soft_entry_a: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ST_ACTIVE && wr_cmd && host_wdata[`CMD_SLEEP_BIT]
    |=> !osc_buffer_enable) else $error("soft pd not entered");
  soft_pins_a: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ST_SOFT_PD && !hard_pd |-> !input_isolate ##1 $stable(pad_out))
    else $error("pins disturbed in soft pd");
  soft_keep_a: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ST_SOFT_PD && !hard_pd |=> $stable(ant_q) && $stable(cmd_q))
    else $error("registers lost in soft pd");
  wake_len_a: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ST_WAKE && state_d == ST_ACTIVE |-> len_q == 16'(WAKE_CLOCKS - 1))
    else $error("wake delay wrong");
  sleep_read_a: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == ST_SOFT_PD || state_q == ST_WAKE) |-> command_readback[`CMD_SLEEP_BIT])
    else $error("sleep bit cleared early");
  ant_off_a: assert property (@(posedge clk) disable iff (!resetn)
    !(ant_q[`ANT_EN1_BIT] && ant_q[`ANT_EN2_BIT]) |-> !antenna_drivers_on)
    else $error("antenna on with enable low");
  spike_reject_a: assert property (@(posedge clk) disable iff (!resetn)
    pin_ok && power_down_reset_n ##1 !power_down_reset_n ##1 power_down_reset_n
    |=> pin_ok) else $error("spike passed filter");
  startup_len_a: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ST_STARTUP && state_d == ST_ACTIVE |-> len_q == 16'(STARTUP_CLOCKS - 1))
    else $error("startup delay wrong");
  ctrl_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !wr_ant && !hard_pd |=> $stable(ant_q)) else $error("control bits changed");
  cmd_done_a: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ST_ACTIVE && command_done && !wr_cmd && !hard_pd |=> cmd_q == `CMD_IDLE)
    else $error("command not returned to idle");

endmodule : power_down_reset_control

`default_nettype wire

// >>> host_model.sv
// Host model that writes the control bytes and drives the power-down pin.
`default_nettype none

module host_model (
  input  wire logic               clk,
  input  wire logic               host_ready,
  output var  logic               host_wr_command,
  output var  logic               host_wr_antenna,
  output var  pd_pkg::reg_byte_t  host_wdata,
  output var  logic               power_down_reset_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import pd_pkg::*;

  // This host writes over parallel strobes, so the serial link's 55h wake byte has no place.
  // Idle host: strobes low, pin released high.
  initial
  begin
    host_wr_command    = 1'b0;
    host_wr_antenna    = 1'b0;
    host_wdata         = 8'h00;
    power_down_reset_n = 1'b1;
  end

  // One write: strobe and data stand from one falling edge to the next.
  // Command bytes from callers keep bits 7:6 at zero.
  // Afterwards the data lines show the inverse byte, so stale data never looks valid.
  task automatic write_reg(input logic to_antenna, input reg_byte_t data);
    @(negedge clk);
    host_wr_command <= !to_antenna;
    host_wr_antenna <= to_antenna;
    host_wdata      <= data;
    @(negedge clk);
    host_wr_command <= 1'b0;
    host_wr_antenna <= 1'b0;
    host_wdata      <= ~data;
  endtask : write_reg

  // Moves the power-down pin; callers keep a real reset low for 21 cycles.
  task automatic drive_pin(input logic level);
    @(negedge clk);
    power_down_reset_n <= level;
  endtask : drive_pin

  // Polls readiness before any further access, giving up after a limit.
  task automatic wait_ready(input int limit, output int n);
    n = 0;
    while (host_ready !== 1'b1 && n < limit)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_ready
endmodule : host_model

`default_nettype wire

// >>> testbench.sv
// Self-checking testbench for the power-down and reset control block.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pd_pkg::*;

  localparam int STARTUP_N = 8;
  localparam int WAKE_N    = 8;

  logic       clk, resetn, power_down_reset_n, clock_stable, command_done;
  logic       host_wr_command, host_wr_antenna, host_ready, osc_enable;
  logic       osc_buffer_enable, current_sinks_on, input_isolate;
  logic       antenna_drivers_on, core_kick;
  reg_byte_t  host_wdata, command_readback, antenna_readback, status_readback;
  logic [3:0] pad_in, pad_in_core, pad_out, pad_out_core;
  int         miscompares;
  int         comparisons;

  power_down_reset_control #(
    .STARTUP_CLOCKS (STARTUP_N),
    .WAKE_CLOCKS    (WAKE_N)
  ) i_power_down_reset_control (
    .clk(clk), .resetn(resetn), .power_down_reset_n(power_down_reset_n),
    .clock_stable(clock_stable), .host_wr_command(host_wr_command),
    .host_wr_antenna(host_wr_antenna), .host_wdata(host_wdata),
    .command_done(command_done), .pad_in(pad_in), .pad_out_core(pad_out_core),
    .command_readback(command_readback), .antenna_readback(antenna_readback),
    .status_readback(status_readback), .host_ready(host_ready),
    .osc_enable(osc_enable), .osc_buffer_enable(osc_buffer_enable),
    .current_sinks_on(current_sinks_on), .input_isolate(input_isolate),
    .pad_in_core(pad_in_core), .pad_out(pad_out),
    .antenna_drivers_on(antenna_drivers_on), .core_kick(core_kick)
  );

  host_model i_host_model (
    .clk(clk), .host_ready(host_ready), .host_wr_command(host_wr_command),
    .host_wr_antenna(host_wr_antenna), .host_wdata(host_wdata),
    .power_down_reset_n(power_down_reset_n)
  );

  // Clock at 200 MHz.
  always #2.5 clk = ~clk;

  // Compares one value and reports a mismatch at once.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // Reset state, then the start-up wait once the clock is reported stable.
  task automatic test_startup;
    int n;
    check("osc_enable", osc_enable, 1'b0);
    check("current_sinks_on", current_sinks_on, 1'b0);
    check("input_isolate", input_isolate, 1'b1);
    check("pad_in_core", pad_in_core, 4'h0);
    resetn = 1'b1;
    repeat (10) @(negedge clk);
    check("host_ready early", host_ready, 1'b0);
    check("osc_enable restart", osc_enable, 1'b1);
    clock_stable = 1'b1;
    i_host_model.wait_ready(STARTUP_N + 20, n);
    check("startup clocks", 8'(n), 8'(STARTUP_N + 1));
    check("status active", status_readback, 8'h01);
  endtask : test_startup

  // Every pair of enables; only both set turns the drivers on.
  task automatic test_antenna;
    for (int i = 0; i < 4; i++)
    begin
      i_host_model.write_reg(1'b1, 8'hA4 | 8'(i));
      check("antenna_readback", antenna_readback, 8'hA4 | 8'(i));
      check("antenna_drivers_on", antenna_drivers_on, i == 3);
    end
  endtask : test_antenna

  // Sleep, live inputs, frozen outputs, retained bytes, counted wake.
  task automatic test_soft_pd;
    int n;
    pad_out_core = 4'h5;
    repeat (2) @(negedge clk);
    check("pad_out active", pad_out, 4'h5);
    i_host_model.write_reg(1'b0, 8'h13);
    check("sleep readback", command_readback, 8'h13);
    check("osc_buffer_enable", osc_buffer_enable, 1'b0);
    check("current_sinks_on", current_sinks_on, 1'b0);
    check("status sleep", status_readback, 8'h02);
    pad_out_core = 4'hA;
    pad_in = 4'h9;
    repeat (2) @(negedge clk);
    check("pad_out frozen", pad_out, 4'h5);
    check("pad_in_core live", pad_in_core, 4'h9);
    check("antenna kept", antenna_readback, 8'hA7);
    i_host_model.write_reg(1'b0, 8'h03);
    check("sleep bit holds", command_readback, 8'h13);
    check("status wake", status_readback, 8'h06);
    i_host_model.write_reg(1'b0, 8'h13);
    check("back to sleep", status_readback, 8'h02);
    check("sleep bit again", command_readback, 8'h13);
    i_host_model.write_reg(1'b0, 8'h03);
    i_host_model.wait_ready(WAKE_N + 20, n);
    check("wake clocks", 8'(n), 8'(WAKE_N));
    check("sleep bit cleared", command_readback, 8'h03);
  endtask : test_soft_pd

  // Hardware return of the code field, and the write-only kick bit.
  task automatic test_command;
    int k;
    command_done = 1'b1;
    @(negedge clk);
    command_done = 1'b0;
    check("code idle", command_readback, 8'h00);
    check("antenna untouched", antenna_readback, 8'hA7);
    i_host_model.write_reg(1'b0, 8'h21);
    check("kick reads zero", command_readback, 8'h01);
    k = int'(core_kick === 1'b1);
    repeat (3)
    begin
      @(negedge clk);
      k += int'(core_kick === 1'b1);
    end
    check("kick pulses", 8'(k), 8'h01);
  endtask : test_command

  // A one-cycle spike, then a held hard power-down and its restart.
  task automatic test_hard_pd;
    int n;
    i_host_model.drive_pin(1'b0);
    i_host_model.drive_pin(1'b1);
    repeat (3) @(negedge clk);
    check("spike ignored", host_ready, 1'b1);
    i_host_model.drive_pin(1'b0);
    repeat (10) @(negedge clk);
    check("osc_enable off", osc_enable, 1'b0);
    check("sinks off", current_sinks_on, 1'b0);
    check("inputs isolated", input_isolate, 1'b1);
    check("inputs clamped", pad_in_core, 4'h0);
    pad_out_core = 4'h3;
    repeat (10) @(negedge clk);
    check("outputs frozen", pad_out, 4'hA);
    i_host_model.drive_pin(1'b1);
    i_host_model.wait_ready(STARTUP_N + 20, n);
    check("restart delay", 8'(n), 8'(STARTUP_N + 4));
    check("antenna after restart", antenna_readback, 8'h00);
  endtask : test_hard_pd

  // Main sequence; inputs change only at falling edges.
  initial
  begin
    clk          = 1'b0;
    resetn       = 1'b0;
    clock_stable = 1'b0;
    command_done = 1'b0;
    pad_in       = 4'hF;
    pad_out_core = 4'h0;
    miscompares  = 0;
    comparisons  = 0;
    repeat (8) @(negedge clk);
    test_startup();
    test_antenna();
    test_soft_pd();
    test_command();
    test_hard_pd();
    finish_test();
  end

  // Watchdog well past the hundred or so cycles the tests need.
  initial
  begin
    #25000;
    miscompares++;
    finish_test();
  end
endmodule : testbench

`default_nettype wire
